// ---- lcr_regs.svh ----
/*
 * register offsets, field positions, reset values and counts of the
 * link cycle and receive control block.
 * assumes a word-addressed register port with 8-bit byte addresses.
 */
`ifndef LCR_REGS_SVH
`define LCR_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LCR_OFS_CTRL     8'h08
`define LCR_OFS_STATUS   8'h0c
`define LCR_OFS_MASK     8'h10
`define LCR_OFS_FIFOCTL  8'h14
`define LCR_OFS_ISOCH    8'h18
`define LCR_OFS_TIMER    8'h1c

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define LCR_B_CM         20
`define LCR_B_EXT        21
`define LCR_B_CTE        22
`define LCR_B_PART       23
`define LCR_B_P1         24
`define LCR_B_P2         25
`define LCR_B_RES_LO     26
`define LCR_B_RES_HI     30
`define LCR_B_FB         31
`define LCR_B_RXI        8

// ----------------------------------------------------------------------
// status and mask fields
// ----------------------------------------------------------------------
`define LCR_S_RXDATA     0
`define LCR_S_CYCSTART   1
`define LCR_S_FLUSHED    2
`define LCR_NUM_EVT      3

// ----------------------------------------------------------------------
// field widths, positions and counts
// ----------------------------------------------------------------------
`define LCR_TRIG_W       8
`define LCR_CH_W         6
`define LCR_CH1_LO       8
`define LCR_CH2_LO       0
`define LCR_CNT_W        13
`define LCR_OFS_W        12
`define LCR_TIM_CNT_LO   12
`define LCR_CYC_WRAP     3072
`define LCR_RST_WORD     32'h0000_0000

`endif

// ---- lcr_pkg.sv ----
/*
 * types of the link cycle and receive control block.
 * assumes lcr_regs.svh is on the include path.
 */
`include "lcr_regs.svh"

package lcr_pkg;

    // receiver word stream from the link side
    typedef struct packed {
        logic                  valid;
        logic                  sop;
        logic                  eop;
        logic                  bad;
        logic                  iso;
        logic [`LCR_CH_W-1:0]  chan;
        logic [31:0]           data;
    } lcr_rx_word_t;

    // writes toward the receive fifo
    typedef struct packed {
        logic                  wr;
        logic                  commit;
        logic                  flush;
        logic [31:0]           data;
    } lcr_fifo_wr_t;

    typedef enum logic [1:0] {
        LCR_RX_IDLE,
        LCR_RX_RECV,
        LCR_RX_DROP
    } lcr_rx_st_t;

endpackage : lcr_pkg

// ---- lcr_ctrl.sv ----
/*
 * link cycle and receive control: control word, cycle timer, cycle
 * start requests, receive filtering, block partitioning, flushing.
 * assumes all inputs synchronous to clk_sys_in, and a fifo that takes
 * words, commits or drops the uncommitted part on request.
 */
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "lcr_regs.svh"

// Overview of operation
// - cycle master active only when control bit 20 set and node is root
// - active cycle master requests a cycle start on every count increment made while timer enable bit 22 set
// - cycle master bit survives bus reset, cleared only by a control write or by rst_n_in
// - external select set: input rising edge bumps count, zeroes offset
// - external select clear: count bumps only on offset rollover
// - cycle offset counts only while timer enable bit 22 set
// - no cycle start is requested while timer enable is clear
// - partition enable splits packets into trigger size blocks
// - block length comes from the fifo control trigger size field
// - each finished block is committed and flagged for the host
// - port one enabled accepts iso packets matching channel one field
// - port two enabled accepts iso packets matching channel two field
// - flush bad set discards bad or overflowed packets
// - a flushed packet never sets the receiver has data flag
// - flush bad set forces partitioning off
// - receiver has data flag set on each finished block or unflushed packet
// - iso receive enable clear rejects all iso packets
module lcr_ctrl
    import lcr_pkg::*;
#(
    parameter int CYC_WRAP = `LCR_CYC_WRAP
) (
    // clock, reset, enable
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic         ce_in,
    // register port
    input  wire logic [7:0]   addr_in,
    input  wire logic [31:0]  wr_data_in,
    input  wire logic         wr_in,
    input  wire logic         rd_in,
    output logic [31:0]       rd_data_out,
    // link side
    input  wire logic         root_in,
    input  wire logic         external_cycle_input,
    input  wire lcr_rx_word_t rx_in,
    input  wire logic         fifo_full_in,
    // results
    output lcr_fifo_wr_t      fifo_out,
    output logic              cyc_start_out,
    output logic              irq_out
);

    typedef struct packed {
        logic [31:0]             ctrl;
        logic [`LCR_TRIG_W-1:0]  trig;
        logic [`LCR_CH_W-1:0]    ch1;
        logic [`LCR_CH_W-1:0]    ch2;
        logic [`LCR_NUM_EVT-1:0] status;
        logic [`LCR_NUM_EVT-1:0] mask;
        logic [`LCR_OFS_W-1:0]   offset;
        logic [`LCR_CNT_W-1:0]   count;
        logic                    cyc_q;
        lcr_rx_st_t              rx;
        logic [`LCR_TRIG_W-1:0]  blk;
        logic                    bad;
        logic [31:0]             rdata;
        lcr_fifo_wr_t            fifo;
        logic                    cstart;
        logic                    irq;
    } lcr_state_t;

    localparam logic [31:0] WMASK = (32'h1 << `LCR_B_CM)
        | (32'h1 << `LCR_B_EXT) | (32'h1 << `LCR_B_CTE)
        | (32'h1 << `LCR_B_PART) | (32'h1 << `LCR_B_P1)
        | (32'h1 << `LCR_B_P2) | (32'h1 << `LCR_B_FB)
        | (32'h1 << `LCR_B_RXI);
    localparam logic [`LCR_OFS_W-1:0] WRAP_M1 =
        `LCR_OFS_W'(CYC_WRAP - 1);

    lcr_state_t st;
    lcr_state_t next_st;

    logic wr_ctrl;
    logic cyc_edge;
    logic bump;
    logic part_on;
    logic accept;
    logic take;
    logic blk_done;
    logic bad_end;
    logic [`LCR_NUM_EVT-1:0] evt;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        evt = '0;
        next_st.fifo = '0;
        next_st.cstart = 1'b0;
        wr_ctrl = wr_in && addr_in == `LCR_OFS_CTRL;

        // register writes
        if (wr_ctrl) begin
            next_st.ctrl = wr_data_in & WMASK;
        end
        if (wr_in && addr_in == `LCR_OFS_MASK) begin
            next_st.mask = wr_data_in[`LCR_NUM_EVT-1:0];
        end
        if (wr_in && addr_in == `LCR_OFS_FIFOCTL) begin
            next_st.trig = wr_data_in[`LCR_TRIG_W-1:0];
        end
        if (wr_in && addr_in == `LCR_OFS_ISOCH) begin
            next_st.ch1 = wr_data_in[`LCR_CH1_LO +: `LCR_CH_W];
            next_st.ch2 = wr_data_in[`LCR_CH2_LO +: `LCR_CH_W];
        end

        // cycle timer
        next_st.cyc_q = external_cycle_input;
        cyc_edge = external_cycle_input && !st.cyc_q;
        bump = 1'b0;
        if (st.ctrl[`LCR_B_EXT] && cyc_edge) begin
            next_st.offset = '0;
            bump = 1'b1;
        end else if (st.ctrl[`LCR_B_CTE]) begin
            if (st.offset == WRAP_M1) begin
                next_st.offset = '0;
                bump = !st.ctrl[`LCR_B_EXT];
            end else begin
                next_st.offset = st.offset + 1'b1;
            end
        end
        if (bump) begin
            next_st.count = st.count + 1'b1;
        end
        // master bit is left alone here on bus reset
        if (bump && st.ctrl[`LCR_B_CM] && root_in
                && st.ctrl[`LCR_B_CTE]) begin
            next_st.cstart = 1'b1;
            evt[`LCR_S_CYCSTART] = 1'b1;
        end

        // receive filter and partitioning
        part_on = st.ctrl[`LCR_B_PART] && !st.ctrl[`LCR_B_FB]
            && st.trig != '0;
        accept = !rx_in.iso
            || (st.ctrl[`LCR_B_RXI] && (
                (st.ctrl[`LCR_B_P1] && rx_in.chan == st.ch1)
             || (st.ctrl[`LCR_B_P2] && rx_in.chan == st.ch2)));
        take = rx_in.valid && (st.rx == LCR_RX_RECV
            || (st.rx == LCR_RX_IDLE && rx_in.sop && accept));
        blk_done = 1'b0;
        bad_end = 1'b0;
        case (st.rx)
            LCR_RX_IDLE: begin
                next_st.bad = 1'b0;
                next_st.blk = '0;
                if (rx_in.valid && rx_in.sop && !rx_in.eop) begin
                    next_st.rx = accept ? LCR_RX_RECV : LCR_RX_DROP;
                end
            end
            LCR_RX_RECV: begin
                if (rx_in.valid && rx_in.eop) begin
                    next_st.rx = LCR_RX_IDLE;
                end
            end
            LCR_RX_DROP: begin
                if (rx_in.valid && rx_in.eop) begin
                    next_st.rx = LCR_RX_IDLE;
                end
            end
            default: begin
                next_st.rx = LCR_RX_IDLE;
            end
        endcase
        if (take) begin
            next_st.fifo.wr = !fifo_full_in;
            next_st.fifo.data = rx_in.data;
            if (fifo_full_in) begin
                next_st.bad = 1'b1;
            end
            if (rx_in.eop) begin
                // clean packet state for a back to back sop
                next_st.bad = 1'b0;
                next_st.blk = '0;
                bad_end = st.bad || rx_in.bad || fifo_full_in;
                if (bad_end && st.ctrl[`LCR_B_FB]) begin
                    next_st.fifo.flush = 1'b1;
                    evt[`LCR_S_FLUSHED] = 1'b1;
                end else begin
                    blk_done = 1'b1;
                end
            end else if (part_on) begin
                next_st.blk = st.blk + 1'b1;
                if (st.blk + 1'b1 == st.trig) begin
                    next_st.blk = '0;
                    blk_done = 1'b1;
                end
            end
        end
        if (blk_done) begin
            next_st.fifo.commit = 1'b1;
            evt[`LCR_S_RXDATA] = 1'b1;
        end

        // sticky status, set wins over write-one clear
        if (wr_in && addr_in == `LCR_OFS_STATUS) begin
            next_st.status = st.status & ~wr_data_in[`LCR_NUM_EVT-1:0];
        end
        next_st.status = next_st.status | evt;
        next_st.irq = |(next_st.status & next_st.mask);

        // read data, one cycle after the strobe
        next_st.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                `LCR_OFS_CTRL: next_st.rdata = st.ctrl;
                `LCR_OFS_STATUS: next_st.rdata = 32'(st.status);
                `LCR_OFS_MASK: next_st.rdata = 32'(st.mask);
                `LCR_OFS_FIFOCTL: next_st.rdata = 32'(st.trig);
                `LCR_OFS_ISOCH: begin
                    next_st.rdata[`LCR_CH1_LO +: `LCR_CH_W] = st.ch1;
                    next_st.rdata[`LCR_CH2_LO +: `LCR_CH_W] = st.ch2;
                end
                `LCR_OFS_TIMER: begin
                    next_st.rdata[`LCR_OFS_W-1:0] = st.offset;
                    next_st.rdata[`LCR_TIM_CNT_LO +: `LCR_CNT_W] =
                        st.count;
                end
                default: next_st.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
            st.ctrl <= `LCR_RST_WORD;
            st.rx <= LCR_RX_IDLE;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign rd_data_out = st.rdata;
    assign fifo_out = st.fifo;
    assign cyc_start_out = st.cstart;
    assign irq_out = st.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    master_gate_a: assert property (
        $past(ce_in) && cyc_start_out |->
        $past(st.ctrl[`LCR_B_CM] && root_in && st.ctrl[`LCR_B_CTE]))
        else $error("cycle start without active master");
    reserved_zero_a: assert property (
        $past(ce_in && rd_in && addr_in == `LCR_OFS_CTRL) |->
        rd_data_out[`LCR_B_RES_HI:`LCR_B_RES_LO] == '0)
        else $error("reserved control bits read nonzero");
    master_hold_a: assert property (
        $fell(st.ctrl[`LCR_B_CM]) |->
        $past(ce_in && wr_in && addr_in == `LCR_OFS_CTRL))
        else $error("master bit cleared without a write");
    ext_cycle_a: assert property (
        ce_in && st.ctrl[`LCR_B_EXT] && external_cycle_input
        && !st.cyc_q |=> st.offset == '0
        && st.count == $past(st.count) + 1'b1)
        else $error("external edge did not bump the count");
    rollover_a: assert property (
        ce_in && !st.ctrl[`LCR_B_EXT] && st.ctrl[`LCR_B_CTE]
        && st.offset == WRAP_M1 |=> st.offset == '0
        && st.count == $past(st.count) + 1'b1)
        else $error("rollover did not bump the count");
    offset_hold_a: assert property (
        !st.ctrl[`LCR_B_CTE] && !st.ctrl[`LCR_B_EXT] |=>
        $stable(st.offset))
        else $error("offset moved with timer disabled");
    flush_flag_a: assert property (
        fifo_out.flush && !$past(st.status[`LCR_S_RXDATA]) |->
        !st.status[`LCR_S_RXDATA])
        else $error("flushed packet raised the data flag");
    no_part_a: assert property (
        $past(ce_in && st.ctrl[`LCR_B_FB]) && fifo_out.commit |->
        $past(rx_in.eop))
        else $error("block committed mid packet under flush bad");
    iso_gate_a: assert property (
        ce_in && !st.ctrl[`LCR_B_RXI] && st.rx == LCR_RX_IDLE
        && rx_in.valid && rx_in.sop && rx_in.iso |=> !fifo_out.wr)
        else $error("iso packet taken with iso receive off");

    // ------------------------------------------------------------------
    // further timer, control word and receive checks
    // ------------------------------------------------------------------
    start_on_bump_a: assert property (
        $changed(st.count) && $past(st.ctrl[`LCR_B_CM] && root_in
        && st.ctrl[`LCR_B_CTE]) |-> cyc_start_out)
        else $error("count bump without a cycle start");
    start_bump_a: assert property (
        $past(ce_in) && cyc_start_out |-> $changed(st.count))
        else $error("cycle start without a count bump");
    offset_step_a: assert property (
        ce_in && st.ctrl[`LCR_B_CTE] && st.offset != WRAP_M1
        && !(st.ctrl[`LCR_B_EXT] && external_cycle_input && !st.cyc_q)
        |=> st.offset == $past(st.offset) + 1'b1)
        else $error("enabled offset did not count");
    count_still_a: assert property (
        ce_in && !st.ctrl[`LCR_B_EXT]
        && !(st.ctrl[`LCR_B_CTE] && st.offset == WRAP_M1)
        |=> $stable(st.count))
        else $error("count moved without a rollover");
    ext_only_a: assert property (
        ce_in && st.ctrl[`LCR_B_EXT]
        && !(external_cycle_input && !st.cyc_q) |=> $stable(st.count))
        else $error("count moved without an external edge");
    ctrl_still_a: assert property (
        !(ce_in && wr_in && addr_in == `LCR_OFS_CTRL) |=> $stable(st.ctrl))
        else $error("control word changed without a write");
    ctrl_write_a: assert property (
        ce_in && wr_in && addr_in == `LCR_OFS_CTRL |=>
        st.ctrl[`LCR_B_RES_HI:`LCR_B_RES_LO] == '0
        && st.ctrl[`LCR_B_FB] == $past(wr_data_in[`LCR_B_FB]))
        else $error("control write not taken as masked");
    port_one_a: assert property (
        ce_in && st.rx == LCR_RX_IDLE && rx_in.valid && rx_in.sop
        && rx_in.iso && st.ctrl[`LCR_B_RXI] && st.ctrl[`LCR_B_P1]
        && rx_in.chan == st.ch1 |=> fifo_out.wr == !$past(fifo_full_in))
        else $error("port one packet not taken");
    port_two_a: assert property (
        ce_in && st.rx == LCR_RX_IDLE && rx_in.valid && rx_in.sop
        && rx_in.iso && st.ctrl[`LCR_B_RXI] && st.ctrl[`LCR_B_P2]
        && rx_in.chan == st.ch2 |=> fifo_out.wr == !$past(fifo_full_in))
        else $error("port two packet not taken");
    iso_reject_a: assert property (
        ce_in && st.rx == LCR_RX_IDLE && rx_in.valid && rx_in.sop
        && rx_in.iso && !(st.ctrl[`LCR_B_P1] && rx_in.chan == st.ch1)
        && !(st.ctrl[`LCR_B_P2] && rx_in.chan == st.ch2) |=> !fifo_out.wr)
        else $error("unmatched iso packet taken");
    part_only_a: assert property (
        $past(ce_in && !rx_in.eop) && fifo_out.commit |->
        $past(st.ctrl[`LCR_B_PART]))
        else $error("block committed mid packet without partitioning");
    block_len_a: assert property (
        $past(ce_in && !rx_in.eop && st.ctrl[`LCR_B_PART]
        && !st.ctrl[`LCR_B_FB]) && fifo_out.commit
        |-> $past(st.blk) + 1'b1 == $past(st.trig))
        else $error("block length differs from trigger size");
    data_flag_a: assert property (
        fifo_out.commit |-> st.status[`LCR_S_RXDATA])
        else $error("finished block did not set the data flag");
    flush_gate_a: assert property (
        $past(ce_in) && fifo_out.flush |-> $past(st.ctrl[`LCR_B_FB]))
        else $error("packet flushed with flush bad clear");
    flush_bad_a: assert property (
        ce_in && st.ctrl[`LCR_B_FB] && st.rx == LCR_RX_RECV
        && rx_in.valid && rx_in.eop && rx_in.bad |=> fifo_out.flush)
        else $error("bad packet not flushed");
    flush_only_a: assert property (
        fifo_out.flush |-> !fifo_out.commit)
        else $error("flushed packet also committed");

    cyc_start_c: cover property (cyc_start_out);
    mid_block_c: cover property (
        fifo_out.commit && $past(!rx_in.eop));
    flush_c: cover property (fifo_out.flush);
    ext_edge_c: cover property (
        st.ctrl[`LCR_B_EXT] && external_cycle_input && !st.cyc_q);
    iso_two_c: cover property (
        st.ctrl[`LCR_B_P2] && fifo_out.wr && fifo_out.commit);

endmodule : lcr_ctrl

// ---- lcr_link_model.sv ----
/*
 * link side partner: drives the receive word stream and the fifo full
 * level, and notes every word that the block should pass on.
 * assumes send() is called from one process, between clock edges.
 */
`timescale 1ns/1ns

module lcr_link_model
    import lcr_pkg::*;
(
    // clock
    input  wire logic    clk_sys_in,
    // stream toward the block
    output lcr_rx_word_t rx_out,
    output logic         full_out
);
    logic [31:0] exp_q[$];

    initial begin
        rx_out   = '0;
        full_out = 1'b0;
    end

    // ------------------------------------------------------------------
    // one whole packet, sop to eop, one word per cycle
    // ------------------------------------------------------------------
    task automatic send(input logic iso, input logic [5:0] ch,
                        input int n, input logic bad, input int full_at,
                        input logic keep);
        logic [31:0] d;
        for (int i = 0; i < n; i++) begin
            d = $urandom;
            @(posedge clk_sys_in);
            rx_out   <= '{1'b1, i == 0, i == n - 1, bad && i == n - 1,
                          iso, ch, d};
            full_out <= (i == full_at);
            if (keep)
                exp_q.push_back(d);
        end
        // released stream shows inverted data, not the last word
        @(posedge clk_sys_in);
        rx_out   <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, ~ch, ~d};
        full_out <= 1'b0;
    endtask : send
endmodule : lcr_link_model

// ---- lcr_ctrl_bench.sv ----
/*
 * self-checking bench of the link cycle and receive control block.
 * assumes lcr_pkg, lcr_regs.svh and lcr_link_model are compiled first.
 */
`timescale 1ns/1ns
`include "lcr_regs.svh"

module lcr_ctrl_bench
    import lcr_pkg::*;
;
    logic         clk_sys_in;
    logic         rst_n_in;
    logic         ce;
    logic [7:0]   addr;
    logic [31:0]  wdata;
    logic         wr;
    logic         rd;
    logic [31:0]  rd_data;
    logic         root;
    logic         cyc_in;
    lcr_rx_word_t rx;
    logic         full;
    lcr_fifo_wr_t fifo;
    logic         cyc_start;
    logic         irq;
    logic         rd_q;
    logic [31:0]  rd_exp[$];
    int           n_errors;
    int           n_tests;
    int           n_wr;
    int           n_cm;
    int           n_fl;
    int           n_cyc;

    lcr_ctrl #(.CYC_WRAP(4)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rd_data), .root_in(root),
        .external_cycle_input(cyc_in), .rx_in(rx), .fifo_full_in(full),
        .fifo_out(fifo), .cyc_start_out(cyc_start), .irq_out(irq));

    lcr_link_model link_u (
        .clk_sys_in(clk_sys_in), .rx_out(rx), .full_out(full));

    always #10 clk_sys_in = ~clk_sys_in;

    // ------------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // result watcher: takes the oldest note whenever a result appears
    always @(posedge clk_sys_in) begin
        if (rd_q)
            check("read data", rd_data, rd_exp.pop_front());
        rd_q <= rd;
        if (fifo.wr && link_u.exp_q.size() > 0)
            check("fifo data", fifo.data, link_u.exp_q.pop_front());
        n_wr  += fifo.wr;
        n_cm  += fifo.commit;
        n_fl  += fifo.flush;
        n_cyc += cyc_start;
    end

    // ------------------------------------------------------------------
    // register port and scenario tasks
    // ------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd   <= 1'b1;
        rd_exp.push_back(e);
        @(posedge clk_sys_in);
        rd   <= 1'b0;
    endtask : rd_reg

    task automatic cyc_win(input int n, input int e);
        int c;
        repeat (4) @(posedge clk_sys_in);
        #1 c = n_cyc;
        repeat (n) @(posedge clk_sys_in);
        #1 check("cycle starts", n_cyc - c, e);
        @(posedge clk_sys_in);
    endtask : cyc_win

    task automatic ext_win(input int e);
        int c;
        repeat (4) @(posedge clk_sys_in);
        #1 c = n_cyc;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_in);
            cyc_in <= 1'b1;
            repeat (3) @(posedge clk_sys_in);
            cyc_in <= 1'b0;
            repeat (3) @(posedge clk_sys_in);
        end
        #1 check("external starts", n_cyc - c, e);
    endtask : ext_win

    task automatic pkt(input logic iso, input logic [5:0] ch, input int n,
                       input logic bad, input int fa, input logic keep,
                       input int ewr, ecm, efl, input logic [31:0] est);
        int w;
        int c;
        int f;
        w = n_wr;
        c = n_cm;
        f = n_fl;
        link_u.send(iso, ch, n, bad, fa, keep);
        repeat (3) @(posedge clk_sys_in);
        #1 if (ewr >= 0)
            check("fifo writes", n_wr - w, ewr);
        check("commits", n_cm - c, ecm);
        check("flushes", n_fl - f, efl);
        check("irq", irq, est[0]);
        rd_reg(`LCR_OFS_STATUS, est);
        wr_reg(`LCR_OFS_STATUS, 32'h0000_0007);
    endtask : pkt

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        rst_n_in = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        root = 1'b0;
        cyc_in = 1'b0;
        rd_q = 1'b0;
        void'($urandom(32'h4ca0));
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_reg(`LCR_OFS_CTRL, `LCR_RST_WORD);
        wr_reg(`LCR_OFS_CTRL, 32'hffff_ffff);
        rd_reg(`LCR_OFS_CTRL, 32'h83f0_0100);
        rd_reg(8'h40, 32'h0);
        wr_reg(`LCR_OFS_CTRL, 32'h0050_0000);
        root <= 1'b1;
        cyc_win(40, 10);
        root <= 1'b0;
        cyc_win(40, 0);
        wr_reg(`LCR_OFS_CTRL, 32'h0040_0000);
        root <= 1'b1;
        cyc_win(40, 0);
        wr_reg(`LCR_OFS_CTRL, 32'h0010_0000);
        cyc_win(40, 0);
        wr_reg(`LCR_OFS_CTRL, 32'h0030_0000);
        ext_win(0);
        wr_reg(`LCR_OFS_CTRL, 32'h0070_0000);
        ext_win(5);
        wr_reg(`LCR_OFS_CTRL, 32'h0000_0100);
        wr_reg(`LCR_OFS_MASK, 32'h0000_0002);
        repeat (2) @(posedge clk_sys_in);
        #1 check("irq raised", irq, 1'b1);
        wr_reg(`LCR_OFS_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys_in);
        #1 check("irq masked", irq, 1'b0);
        wr_reg(`LCR_OFS_STATUS, 32'h0000_0007);
        wr_reg(`LCR_OFS_MASK, 32'h0000_0001);
        wr_reg(`LCR_OFS_ISOCH, 32'h0000_0509);
        wr_reg(`LCR_OFS_FIFOCTL, 32'h0000_0000);
        pkt(0, 0, 3, 0, -1, 1, 3, 1, 0, 1);
        pkt(1, 5, 2, 0, -1, 0, 0, 0, 0, 0);
        wr_reg(`LCR_OFS_CTRL, 32'h0100_0100);
        pkt(1, 5, 2, 0, -1, 1, 2, 1, 0, 1);
        pkt(1, 9, 2, 0, -1, 0, 0, 0, 0, 0);
        wr_reg(`LCR_OFS_CTRL, 32'h0300_0100);
        pkt(1, 9, 2, 0, -1, 1, 2, 1, 0, 1);
        wr_reg(`LCR_OFS_CTRL, 32'h0300_0000);
        pkt(1, 5, 2, 0, -1, 0, 0, 0, 0, 0);
        wr_reg(`LCR_OFS_FIFOCTL, 32'h0000_0002);
        wr_reg(`LCR_OFS_CTRL, 32'h0080_0000);
        pkt(0, 0, 5, 0, -1, 1, 5, 3, 0, 1);
        wr_reg(`LCR_OFS_CTRL, 32'h8080_0000);
        pkt(0, 0, 5, 0, -1, 1, 5, 1, 0, 1);
        pkt(0, 0, 3, 1, -1, 1, 3, 0, 1, 4);
        pkt(0, 0, 4, 0, 1, 0, 3, 0, 1, 4);
        repeat (4) @(posedge clk_sys_in);
        complete_run();
    end

    initial begin
        n_errors = 0;
        n_tests = 0;
        n_wr = 0;
        n_cm = 0;
        n_fl = 0;
        n_cyc = 0;
        #(20 * 6000);
        n_errors++;
        complete_run();
    end
endmodule : lcr_ctrl_bench
